// ==== hdl/pas_regs.svh ====
// register offsets, field positions, reset values and counts
`ifndef PAS_REGS_SVH
`define PAS_REGS_SVH
`define PAS_REG_FAST_RX_STATUS 5'h11
`define PAS_REG_RX_ERROR_COUNT 5'h12
`define PAS_REG_FALSE_CARRIER_COUNT 5'h13
`define PAS_REG_AUX_CONTROL_STATUS 5'h18
`define PAS_ST_LOCKED 9
`define PAS_ST_LINK 8
`define PAS_ST_REMOTE_FAULT 7
`define PAS_AUX_JABBER_DIS 15
`define PAS_AUX_FORCE_LINK 14
`define PAS_AUX_FULL_POWER 8
`define PAS_AUX_SQ_MSB 7
`define PAS_AUX_SQ_LSB 6
`define PAS_AUX_EDGE_MSB 5
`define PAS_AUX_EDGE_LSB 4
`define PAS_EDGE_RST 2'h3
`define PAS_SQ_RST 2'h0
`define PAS_SQ_ILLEGAL 2'h3
`define PAS_RXERR_MAX 16'h00ff
`define PAS_FCC_MAX 8'hff
`define PAS_PREAMBLE_LEN 6'h20
`define PAS_OP_READ 2'h2
`define PAS_OP_WRITE 2'h1
`define PAS_HDR_LAST 4'hc
`define PAS_DATA_LAST 4'hf
`endif

// ==== hdl/pas_pkg.sv ====
// types of the phy status and counter register bank
package pas_pkg;
  typedef enum logic [1:0] {st_pre, st_hdr, st_ta, st_data} pas_fsm_t;

  typedef struct packed {
    logic false_carrier;
    logic bad_esd;
    logic bad_code;
    logic tx_err_code;
    logic lock_lost;
    logic mlt3_err;
    logic rx_err_pkt;
  } pas_rx_events_t;

  typedef struct packed {
    logic jabber_dis;
    logic force_link;
    logic full_power;
    logic [1:0] squelch_level_select;
    logic [1:0] edge_rate;
  } pas_aux_cfg_t;

  typedef struct packed {
    logic mdc_q;
    pas_fsm_t fsm;
    logic [5:0] pre;
    logic [3:0] cnt;
    logic [11:0] hdr;
    logic [4:0] regad;
    logic is_read;
    logic [15:0] rd_shift;
    logic [15:0] wr_shift;
    logic mdio_o;
    logic mdio_oe;
    logic [5:0] lat;
    logic [5:0] snap_lat;
    logic [15:0] rxerr;
    logic [7:0] fcc;
    pas_aux_cfg_t cfg;
  } pas_state_t;
endpackage

// ==== hdl/pas_phy_aux_status_counters.sv ====
// phy receive status, error counters and aux control over mdio
`include "pas_regs.svh"

module pas_phy_aux_status_counters
  import pas_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [4:0] i_phy_addr,
  input wire logic i_mdc,
  input wire logic i_mdio,
  output logic o_mdio,
  output logic o_mdio_oe,
  input wire pas_rx_events_t i_events,
  input wire logic i_descr_locked,
  input wire logic i_link_good,
  input wire logic i_remote_fault,
  input wire logic i_ctrl_an_enable,
  input wire logic i_ctrl_speed_sel,
  input wire logic i_autoneg_enable_pin,
  input wire logic i_force_fast_speed_pin,
  input wire logic i_speed_fast,
  input wire logic i_an_busy,
  input wire logic i_full_duplex,
  output logic o_jabber_disable,
  output logic o_force_link,
  output logic o_full_power,
  output logic [1:0] o_squelch_level_select,
  output logic [1:0] o_edge_rate
);
  pas_state_t st_r;
  pas_state_t st_nxt;
  logic rise;
  logic [12:0] hdr_w;
  logic [4:0] sel_reg;
  logic hit;
  logic snap;
  logic rd_done;
  logic wr_done;
  logic [15:0] rd_word;
  logic [15:0] stat_word;
  logic [15:0] aux_word;
  logic [15:0] wdat;
  logic [5:0] ev_lat;
  logic [5:0] clr_mask;
  logic an_ind;
  logic force_fast_speed_pin_ind;
  logic snap_stat;
  logic snap_rxerr;
  logic snap_fcc;
  logic snap_aux;
  logic wr_aux;

  assign rise = i_mdc & ~st_r.mdc_q;
  assign hdr_w = {st_r.hdr, i_mdio};
  assign sel_reg = hdr_w[4:0];
  assign wdat = {st_r.wr_shift[14:0], i_mdio};
  assign ev_lat = {i_events.false_carrier, i_events.bad_esd,
                   i_events.bad_code, i_events.tx_err_code,
                   i_events.lock_lost, i_events.mlt3_err};
  assign an_ind = i_ctrl_an_enable & i_autoneg_enable_pin;
  // zero only for the two forced-10 cases
  assign force_fast_speed_pin_ind = ~((~i_autoneg_enable_pin & ~i_force_fast_speed_pin) |
                      (i_autoneg_enable_pin & ~i_ctrl_an_enable &
                       ~i_ctrl_speed_sel));
  assign stat_word = {6'h00, i_descr_locked, i_link_good, i_remote_fault,
                      1'b0, st_r.lat};
  // speed reads 10 while negotiation runs
  assign aux_word = {st_r.cfg.jabber_dis, st_r.cfg.force_link, 5'h00,
                     st_r.cfg.full_power, st_r.cfg.squelch_level_select,
                     st_r.cfg.edge_rate, an_ind, force_fast_speed_pin_ind,
                     i_speed_fast & ~i_an_busy, i_full_duplex};
  assign hit = hdr_w[12] && (hdr_w[9:5] == i_phy_addr) &&
               (sel_reg == `PAS_REG_FAST_RX_STATUS ||
                sel_reg == `PAS_REG_RX_ERROR_COUNT ||
                sel_reg == `PAS_REG_FALSE_CARRIER_COUNT ||
                sel_reg == `PAS_REG_AUX_CONTROL_STATUS);
  assign snap_stat = snap && sel_reg == `PAS_REG_FAST_RX_STATUS;
  assign snap_rxerr = snap && sel_reg == `PAS_REG_RX_ERROR_COUNT;
  assign snap_fcc = snap && sel_reg == `PAS_REG_FALSE_CARRIER_COUNT;
  assign snap_aux = snap && sel_reg == `PAS_REG_AUX_CONTROL_STATUS;
  assign wr_aux = wr_done && st_r.regad == `PAS_REG_AUX_CONTROL_STATUS;
  assign clr_mask = (rd_done && st_r.regad == `PAS_REG_FAST_RX_STATUS) ?
                    st_r.snap_lat : 6'h00;

  always_comb begin
    case (sel_reg)
      `PAS_REG_FAST_RX_STATUS: rd_word = stat_word;
      `PAS_REG_RX_ERROR_COUNT: rd_word = st_r.rxerr;
      `PAS_REG_FALSE_CARRIER_COUNT: rd_word = {8'h00, st_r.fcc};
      `PAS_REG_AUX_CONTROL_STATUS: rd_word = aux_word;
      default: rd_word = 16'h0000;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    snap = 1'b0;
    rd_done = 1'b0;
    wr_done = 1'b0;
    st_nxt.mdc_q = i_mdc;
    if (rise) begin
      unique case (st_r.fsm)
        st_pre: begin
          if (i_mdio) begin
            if (st_r.pre != `PAS_PREAMBLE_LEN) begin
              st_nxt.pre = st_r.pre + 6'h01;
            end
          end else begin
            if (st_r.pre == `PAS_PREAMBLE_LEN) begin
              st_nxt.fsm = st_hdr;
            end
            st_nxt.pre = 6'h00;
            st_nxt.cnt = 4'h0;
          end
        end
        st_hdr: begin
          st_nxt.hdr = hdr_w[11:0];
          st_nxt.cnt = st_r.cnt + 4'h1;
          if (st_r.cnt == `PAS_HDR_LAST) begin
            st_nxt.fsm = st_pre;
            st_nxt.cnt = 4'h0;
            st_nxt.regad = sel_reg;
            if (hit && hdr_w[11:10] == `PAS_OP_READ) begin
              st_nxt.fsm = st_ta;
              st_nxt.is_read = 1'b1;
              st_nxt.rd_shift = rd_word;
              snap = 1'b1;
            end else if (hit && hdr_w[11:10] == `PAS_OP_WRITE) begin
              st_nxt.fsm = st_ta;
              st_nxt.is_read = 1'b0;
            end
          end
        end
        st_ta: begin
          st_nxt.cnt = st_r.cnt + 4'h1;
          if (st_r.cnt == 4'h0) begin
            if (st_r.is_read) begin
              st_nxt.mdio_oe = 1'b1;
              st_nxt.mdio_o = 1'b0;
            end
          end else begin
            st_nxt.fsm = st_data;
            st_nxt.cnt = 4'h0;
            if (st_r.is_read) begin
              st_nxt.mdio_o = st_r.rd_shift[15];
              st_nxt.rd_shift = {st_r.rd_shift[14:0], 1'b0};
            end
          end
        end
        st_data: begin
          st_nxt.cnt = st_r.cnt + 4'h1;
          if (st_r.is_read) begin
            if (st_r.cnt == `PAS_DATA_LAST) begin
              st_nxt.mdio_oe = 1'b0;
              st_nxt.mdio_o = 1'b0;
              rd_done = 1'b1;
            end else begin
              st_nxt.mdio_o = st_r.rd_shift[15];
              st_nxt.rd_shift = {st_r.rd_shift[14:0], 1'b0};
            end
          end else begin
            st_nxt.wr_shift = wdat;
            wr_done = (st_r.cnt == `PAS_DATA_LAST);
          end
          if (st_r.cnt == `PAS_DATA_LAST) begin
            st_nxt.fsm = st_pre;
            st_nxt.cnt = 4'h0;
          end
        end
      endcase
    end
    if (snap_stat) begin
      st_nxt.snap_lat = st_r.lat;
    end
    // only bits already shown are cleared, new events set
    st_nxt.lat = (st_r.lat & ~clr_mask) | ev_lat;
    if (snap_rxerr) begin
      st_nxt.rxerr = {15'h0000, i_events.rx_err_pkt};
    end else if (i_events.rx_err_pkt && st_r.rxerr != `PAS_RXERR_MAX) begin
      st_nxt.rxerr = st_r.rxerr + 16'h0001;
    end
    if (snap_fcc) begin
      st_nxt.fcc = {7'h00, i_events.false_carrier};
    end else if (i_events.false_carrier && st_r.fcc != `PAS_FCC_MAX) begin
      st_nxt.fcc = st_r.fcc + 8'h01;
    end
    if (wr_aux) begin
      st_nxt.cfg.jabber_dis = wdat[`PAS_AUX_JABBER_DIS];
      st_nxt.cfg.force_link = wdat[`PAS_AUX_FORCE_LINK];
      st_nxt.cfg.full_power = wdat[`PAS_AUX_FULL_POWER];
      if (wdat[`PAS_AUX_SQ_MSB:`PAS_AUX_SQ_LSB] != `PAS_SQ_ILLEGAL) begin
        st_nxt.cfg.squelch_level_select =
          wdat[`PAS_AUX_SQ_MSB:`PAS_AUX_SQ_LSB];
      end
      st_nxt.cfg.edge_rate = wdat[`PAS_AUX_EDGE_MSB:`PAS_AUX_EDGE_LSB];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      st_r <= '0;
      st_r.cfg.squelch_level_select <= `PAS_SQ_RST;
      st_r.cfg.edge_rate <= `PAS_EDGE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_mdio = st_r.mdio_o;
  assign o_mdio_oe = st_r.mdio_oe;
  assign o_jabber_disable = st_r.cfg.jabber_dis;
  assign o_force_link = st_r.cfg.force_link;
  assign o_full_power = st_r.cfg.full_power;
  assign o_squelch_level_select = st_r.cfg.squelch_level_select;
  assign o_edge_rate = st_r.cfg.edge_rate;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  a_live_bits_snap: assert property (
    snap_stat |=> st_r.rd_shift[9:7] ==
      {$past(i_descr_locked), $past(i_link_good), $past(i_remote_fault)})
    else $error("live status bits wrong in read word");

  for (genvar gi = 0; gi < 6; gi++) begin : g_lat
    a_latch_sets: assert property (
      ev_lat[gi] |=> st_r.lat[gi] ##1 st_r.lat[gi] || $past(clr_mask[gi]))
      else $error("latched error bit lost its event");
  end

  a_latch_clears: assert property (
    (rd_done && st_r.regad == `PAS_REG_FAST_RX_STATUS && ev_lat == 6'h00)
      |=> (st_r.lat & $past(st_r.snap_lat)) == 6'h00)
    else $error("latched bits not cleared after read");

  a_rxerr_counts: assert property (
    (i_events.rx_err_pkt && !snap_rxerr && st_r.rxerr < `PAS_RXERR_MAX)
      |=> st_r.rxerr == $past(st_r.rxerr) + 16'h0001)
    else $error("receive error counter missed a packet");

  a_rxerr_rdclr: assert property (
    snap_rxerr |=> st_r.rxerr == {15'h0000, $past(i_events.rx_err_pkt)} &&
      st_r.rd_shift == $past(st_r.rxerr))
    else $error("receive error counter not cleared by read");

  a_rxerr_sat: assert property (
    (st_r.rxerr == `PAS_RXERR_MAX && !snap_rxerr)
      |=> st_r.rxerr == `PAS_RXERR_MAX)
    else $error("receive error counter left saturation");

  a_fcc_count: assert property (
    (!snap_fcc && i_events.false_carrier)
      |=> st_r.fcc == (($past(st_r.fcc) == `PAS_FCC_MAX) ?
                       `PAS_FCC_MAX : $past(st_r.fcc) + 8'h01))
    else $error("false carrier counter wrong");

  a_cfg_write: assert property (
    wr_aux |=> {o_jabber_disable, o_force_link, o_full_power, o_edge_rate}
      == {$past(wdat[15]), $past(wdat[14]), $past(wdat[8]),
          $past(wdat[5:4])})
    else $error("aux control write not stored");

  a_squelch_hold: assert property (
    (wr_aux && wdat[7:6] == `PAS_SQ_ILLEGAL) |=> $stable(o_squelch_level_select))
    else $error("illegal squelch code was stored");

  a_reset_vals: assert property (disable iff (1'b0)
    i_reset |=> o_edge_rate == `PAS_EDGE_RST && !o_full_power &&
      !o_jabber_disable && !o_force_link && !o_mdio_oe)
    else $error("aux control reset values wrong");

  a_aux_ind_snap: assert property (
    snap_aux |=> st_r.rd_shift[3:0] == {$past(an_ind), $past(force_fast_speed_pin_ind),
      $past(i_speed_fast & ~i_an_busy), $past(i_full_duplex)})
    else $error("aux indication bits wrong in read word");

  a_fcc_rdclr: assert property (
    snap_fcc |=> st_r.fcc == {7'h00, $past(i_events.false_carrier)} &&
      st_r.rd_shift == {8'h00, $past(st_r.fcc)})
    else $error("false carrier counter not cleared by read");

  a_fcc_sat: assert property (
    (st_r.fcc == `PAS_FCC_MAX && !snap_fcc)
      |=> st_r.fcc == `PAS_FCC_MAX)
    else $error("false carrier counter left saturation");

  a_stat_reserved: assert property (
    snap_stat |=> st_r.rd_shift[15:10] == 6'h00 && !st_r.rd_shift[6])
    else $error("reserved status bits not zero");

  a_aux_reserved: assert property (
    snap_aux |=> st_r.rd_shift[13:9] == 5'h00)
    else $error("reserved aux bits not zero");

  a_ta_drive_low: assert property (
    (rise && st_r.fsm == st_ta && st_r.cnt == 4'h0 && st_r.is_read)
      |=> o_mdio_oe && !o_mdio)
    else $error("turnaround bit not driven low");

  a_rd_release: assert property (
    rd_done |=> !o_mdio_oe)
    else $error("data line not released after read");

  a_oe_only_read: assert property (
    o_mdio_oe |-> st_r.is_read)
    else $error("data line driven outside a read");

  a_refused_quiet: assert property (
    (rise && st_r.fsm == st_hdr && st_r.cnt == `PAS_HDR_LAST && !hit)
      |=> st_r.fsm == st_pre && !o_mdio_oe)
    else $error("unaddressed frame was answered");

  c_read_status: cover property (rd_done &&
    st_r.regad == `PAS_REG_FAST_RX_STATUS);
  c_write_aux: cover property (wr_aux);
  c_rxerr_full: cover property (st_r.rxerr == `PAS_RXERR_MAX);
  c_clear_collide: cover property (clr_mask != 6'h00 && ev_lat != 6'h00);
endmodule

// ==== bench/pas_mdio_station.sv ====
// mdio station manager model: frames at one eighth of the core clock
module pas_mdio_station (
  input wire logic i_core_clk,
  input wire logic i_mdio,
  output logic o_mdc,
  output logic o_mdio,
  output logic o_mdio_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_mdio_oe = 1'b0;
  end
  // data set in the low phase, wire sampled just before the rise
  task automatic bit_xfer(input logic drv, input logic b, output logic r);
    o_mdc = 1'b0;
    o_mdio_oe = drv;
    o_mdio = b;
    repeat (4) @(negedge i_core_clk);
    r = i_mdio;
    o_mdc = 1'b1;
    repeat (4) @(negedge i_core_clk);
  endtask
  // preamble, header, turnaround, 16 data bits msb first, one idle bit
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
      input logic [4:0] ra, input logic [15:0] wd,
      output logic [15:0] rd, output logic ta);
    logic [13:0] hdr;
    logic r;
    logic wx;
    hdr = {2'b01, op, phy, ra};
    wx = (op != 2'b10);
    for (int i = 0; i < 32; i++) bit_xfer(1'b1, 1'b1, r);
    for (int i = 13; i >= 0; i--) bit_xfer(1'b1, hdr[i], r);
    bit_xfer(wx, 1'b1, r);
    bit_xfer(wx, 1'b0, ta);
    for (int i = 15; i >= 0; i--) begin
      bit_xfer(wx, wd[i], r);
      rd[i] = r;
    end
    bit_xfer(1'b0, 1'b1, r);
  endtask
endmodule

// ==== bench/pas_phy_aux_status_counters_tb.sv ====
// bench: mdio register traffic against status, counters and aux control
`include "pas_regs.svh"
module pas_phy_aux_status_counters_tb
  import pas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] PHY = 5'h05;
  logic clk, rst, mdc, m_md, m_oe, d_md, d_oe, md;
  logic lck, lnk, rf, c12, c13, autoneg_enable_pin, force_fast_speed_pin, spd, busy, fdx;
  logic jab, frc, fpw, saw_oe, ta;
  logic [1:0] sq, er, q;
  logic [15:0] rd;
  logic [3:0] v;
  pas_rx_events_t ev;
  int n_mismatch, comparisons;
  // pull-up holds the wire high when nobody drives
  assign md = d_oe ? d_md : (m_oe ? m_md : 1'b1);
  pas_phy_aux_status_counters u_dut (.i_core_clk(clk), .i_reset(rst),
    .i_phy_addr(PHY), .i_mdc(mdc), .i_mdio(md), .o_mdio(d_md),
    .o_mdio_oe(d_oe), .i_events(ev), .i_descr_locked(lck),
    .i_link_good(lnk), .i_remote_fault(rf), .i_ctrl_an_enable(c12),
    .i_ctrl_speed_sel(c13), .i_autoneg_enable_pin(autoneg_enable_pin),
    .i_force_fast_speed_pin(force_fast_speed_pin), .i_speed_fast(spd), .i_an_busy(busy),
    .i_full_duplex(fdx), .o_jabber_disable(jab), .o_force_link(frc),
    .o_full_power(fpw), .o_squelch_level_select(sq), .o_edge_rate(er));
  pas_mdio_station u_sta (.i_core_clk(clk), .i_mdio(md), .o_mdc(mdc),
    .o_mdio(m_md), .o_mdio_oe(m_oe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (d_oe) saw_oe <= 1'b1;
  function automatic logic [3:0] ind();
    return {c12 & autoneg_enable_pin, !((!autoneg_enable_pin & !force_fast_speed_pin) | (autoneg_enable_pin & !c12 & !c13)),
      spd & !busy, fdx};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdr(input logic [4:0] ra);
    u_sta.frame(2'b10, PHY, ra, 16'h0000, rd, ta);
  endtask
  task automatic wrr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] x;
    logic y;
    u_sta.frame(2'b01, PHY, ra, wd, x, y);
  endtask
  // a held event level counts once per clock
  task automatic pulse(input int b, input int n);
    ev[b] = 1'b1;
    repeat (n) @(negedge clk);
    ev[b] = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    saw_oe = 1'b0;
    rst = 1'b1;
    ev = '0;
    {lck, lnk, rf, spd, busy, fdx} = 6'h00;
    {c12, c13, autoneg_enable_pin, force_fast_speed_pin} = 4'b1010;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    rdr(`PAS_REG_AUX_CONTROL_STATUS);
    chk(rd, {12'h003, ind()});
    chk({15'h0000, ta}, 16'h0000);
    chk({9'h000, jab, frc, fpw, sq, er}, 16'h0003);
    wrr(`PAS_REG_AUX_CONTROL_STATUS, 16'hc19f);
    rdr(`PAS_REG_AUX_CONTROL_STATUS);
    chk(rd, {12'hc19, ind()});
    chk({9'h000, jab, frc, fpw, sq, er}, 16'h0079);
    for (int s = 0; s < 4; s++) begin
      q = (s == 3) ? 2'h2 : 2'(s);
      wrr(`PAS_REG_AUX_CONTROL_STATUS, {8'h00, 2'(s), 2'(s), 4'h0});
      rdr(`PAS_REG_AUX_CONTROL_STATUS);
      chk(rd, {8'h00, q, 2'(s), ind()});
      chk({9'h000, jab, frc, fpw, sq, er}, {12'h000, q, 2'(s)});
    end
    for (int i = 0; i < 16; i++) begin
      v = 4'(i);
      {c12, autoneg_enable_pin, force_fast_speed_pin, c13} = v;
      {spd, busy, fdx} = {v[2], v[0], v[1]};
      rdr(`PAS_REG_AUX_CONTROL_STATUS);
      chk({12'h000, rd[3:0]}, {12'h000, ind()});
    end
    for (int j = 0; j < 6; j++) begin
      {lck, lnk, rf} = 3'(j + 1);
      pulse(j + 1, 1);
      rdr(`PAS_REG_FAST_RX_STATUS);
      chk(rd, {6'h00, lck, lnk, rf, 1'b0, 6'(1 << j)});
    end // the single-bit reads above also
    rdr(`PAS_REG_FAST_RX_STATUS);
    chk(rd, {6'h00, lck, lnk, rf, 7'h00});
    pulse(0, 300);
    rdr(`PAS_REG_RX_ERROR_COUNT);
    chk(rd, 16'h00ff);
    pulse(0, 3);
    rdr(`PAS_REG_RX_ERROR_COUNT);
    chk(rd, 16'h0003);
    pulse(6, 300);
    rdr(`PAS_REG_FALSE_CARRIER_COUNT);
    chk(rd, 16'h00ff);
    rdr(`PAS_REG_FALSE_CARRIER_COUNT);
    chk(rd, 16'h0000);
    // events land in the data phase of a clearing status read
    fork
      rdr(`PAS_REG_FAST_RX_STATUS);
      begin
        repeat (400) @(negedge clk);
        ev = 7'h03;
        @(negedge clk);
        ev = '0;
      end
    join
    rdr(`PAS_REG_FAST_RX_STATUS);
    chk(rd, {6'h00, lck, lnk, rf, 7'h01});
    rdr(`PAS_REG_RX_ERROR_COUNT);
    chk(rd, 16'h0001);
    saw_oe = 1'b0;
    u_sta.frame(2'b10, PHY ^ 5'h01, `PAS_REG_AUX_CONTROL_STATUS, 16'h0000,
      rd, ta);
    chk(rd, 16'hffff);
    rdr(5'h14);
    chk(rd, 16'hffff);
    chk({15'h0000, saw_oe}, 16'h0000);
    wrr(`PAS_REG_RX_ERROR_COUNT, 16'h1234);
    rdr(`PAS_REG_RX_ERROR_COUNT);
    chk(rd, 16'h0000);
    tally_and_finish();
  end
endmodule
